// ==== basic_timer_pkg.sv ====
// Package: register map, field positions and shared types of the basic timer
package basic_timer_pkg;
    // Register byte offsets
    localparam logic [7:0] counter_control_off = 8'h00;
    localparam logic [7:0] trigger_control_off = 8'h04;
    localparam logic [7:0] irq_dma_enable_off = 8'h0c;
    localparam logic [7:0] update_status_off = 8'h10;
    localparam logic [7:0] software_event_register_off = 8'h14;
    localparam logic [7:0] counter_value_off = 8'h24;
    localparam logic [7:0] clock_divider_register_off = 8'h28;
    localparam logic [7:0] reload_value_register_off = 8'h2c;
    localparam logic [7:0] debug_control_register_off = 8'h30;
    // Register field positions
    localparam int run_pos = 0;
    localparam int inhibit_pos = 1;
    localparam int source_pos = 2;
    localparam int one_shot_pos = 3;
    localparam int reload_buf_pos = 7;
    localparam int trig_sel_lsb = 4;
    localparam int irq_en_pos = 0;
    localparam int dma_en_pos = 8;
    localparam int flag_pos = 0;
    localparam int force_pos = 0;
    localparam int freeze_pos = 0;
    // Reset values
    localparam logic [15:0] count_rst = 16'h0000;
    localparam logic [7:0] control_rst = 8'h00;
    // Trigger output selections
    localparam logic [2:0] trig_on_reset = 3'h0;
    localparam logic [2:0] trig_on_start = 3'h1;
    localparam logic [2:0] trig_on_update = 3'h2;

    // Control bits gathered together
    typedef struct packed {
        logic reload_buf;
        logic one_shot;
        logic source;
        logic inhibit;
        logic run;
    } ctrl_t;

    // Event outputs travelling together
    typedef struct packed {
        logic irq;
        logic dma;
        logic trig;
    } events_t;
endpackage : basic_timer_pkg

// ==== basic_timer.sv ====
// Basic 16-bit up-counting timer with APB register access
// Contract
// (RULE1) Counter is 16-bit unsigned, counting upward only.
// (RULE2) Counter advances only from the internal timer clock.
// (RULE3) While running, divide timer clock by divider value plus one.
// (RULE4) 16-bit divider gives factors 1 through 65536.
// (RULE5) New divider value waits in a buffer until next update event.
// (RULE6) Count from 0 to reload value, then continue from 0.
// (RULE7) Overflow past reload value generates an update event.
// (RULE8) Writing force-update bit clears counter, makes update; bit self-clears.
// (RULE9) Update event loads buffered reload and divider into active registers.
// (RULE10) Control bit 7 chooses buffered or direct reload value writes.
// (RULE11) Control bit 3: clear and stop at next update; else continue.
// (RULE12) In one-shot, run bit stays set until update, then hardware clears it.
// (RULE13) Software clearing run bit stops counter, value held.
// (RULE14) Control bit 2: 0 all sources request, 1 only overflow requests.
// (RULE15) Control bit 1 suppresses update events and buffer transfers.
// (RULE16) Inhibited force update still clears counter and divider, no event.
// (RULE17) Each update event raises interrupt or DMA request.
// (RULE18) Trigger output toward converter; DMA requests available.
// (RULE19) Debug halt with freeze bit set stops the counter.
// (RULE20) Software uses only full 32-bit word accesses.
// (RULE21) Control bit 0 is the run bit: 0 stop, 1 count.
// (RULE22) Hardware sets update flag per event; software clears by writing zero.
// (RULE23) Interrupt enable bit 0, DMA enable bit 8 gate update requests.
// (RULE24) Trigger select 000 reset, 001 start, 010 update pulses trigger.
// (RULE25) Unbuffered reload writes take effect immediately.
// (RULE26) Forced update restarts divider so next increment is full period later.
`timescale 1ns/1ps
`default_nettype none

module basic_timer #(
    parameter int count_width = 16,
    parameter int divider_width = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Debug halt from the processor
    input wire logic debug_halt,
    // Event outputs
    output basic_timer_pkg::events_t events
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    // Active copies feed the counter; buffered copies
    // hold what software wrote until the next update
    // Divider and reload reads return the buffered copy

    // Control and configuration
    basic_timer_pkg::ctrl_t ctrl_q;
    logic [2:0] trig_sel_q;
    logic irq_en_q;
    logic dma_en_q;
    logic update_flag_q;
    logic freeze_q;

    // Divider path
    logic [divider_width-1:0] div_buf_q;
    logic [divider_width-1:0] div_act_q;
    logic [divider_width-1:0] div_cnt_q;

    // Reload and count
    logic [count_width-1:0] reload_buf_q;
    logic [count_width-1:0] reload_act_q;
    logic [count_width-1:0] count_q;

    // Halt synchroniser flops
    logic halt_s1_q;
    logic halt_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // Every strobe below is qualified by a completed
    // access; software must use whole word writes,
    // there are no byte strobes
    logic access;
    logic wr;
    logic mapped;

    // Word-aligned address hit check
    // Whole byte address compared, so a misaligned
    // address never aliases onto a register
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    // Writes act only in the access cycle that pready closes
    // so a stalled or idle bus never changes state
    assign access = psel && penable && pready;
    assign wr = access && pwrite; // [RULE20]

    // Hits of the mapped registers, for the error answer
    assign mapped = hit(paddr, basic_timer_pkg::counter_control_off)
        || hit(paddr, basic_timer_pkg::trigger_control_off)
        || hit(paddr, basic_timer_pkg::irq_dma_enable_off)
        || hit(paddr, basic_timer_pkg::update_status_off)
        || hit(paddr, basic_timer_pkg::software_event_register_off)
        || hit(paddr, basic_timer_pkg::counter_value_off)
        || hit(paddr, basic_timer_pkg::clock_divider_register_off)
        || hit(paddr, basic_timer_pkg::reload_value_register_off)
        || hit(paddr, basic_timer_pkg::debug_control_register_off);

    // Register write strobes, valid for one access cycle
    logic wr_ctrl;
    logic wr_force;
    logic wr_count;
    logic wr_div;
    logic wr_reload;
    logic wr_status;
    assign wr_ctrl = wr && hit(paddr, basic_timer_pkg::counter_control_off);
    assign wr_force = wr && hit(paddr, basic_timer_pkg::software_event_register_off)
        && pwdata[basic_timer_pkg::force_pos];
    assign wr_count = wr && hit(paddr, basic_timer_pkg::counter_value_off);
    assign wr_div = wr && hit(paddr, basic_timer_pkg::clock_divider_register_off);
    assign wr_reload = wr && hit(paddr, basic_timer_pkg::reload_value_register_off);
    assign wr_status = wr && hit(paddr, basic_timer_pkg::update_status_off);

    // Configuration register strobes
    logic wr_trig;
    logic wr_enable;
    logic wr_freeze;
    assign wr_trig = wr && hit(paddr, basic_timer_pkg::trigger_control_off);
    assign wr_enable = wr && hit(paddr, basic_timer_pkg::irq_dma_enable_off);
    assign wr_freeze = wr && hit(paddr, basic_timer_pkg::debug_control_register_off);

    ////////////////////////////////////////////////////////////////////////
    // Halt synchroniser
    // Halt comes from the processor's domain; two flops
    // keep a metastable sample away from the freeze gate
    // Reset clears both flops, so no false halt after reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            halt_s1_q <= 1'b0;
            halt_s2_q <= 1'b0;
        end else begin
            halt_s1_q <= debug_halt;
            halt_s2_q <= halt_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting datapath
    // A tick is the one-cycle enable from the divider;
    // the counter moves only on ticks, never on a second clock
    logic frozen;
    logic counting;
    logic tick;
    logic overflow;
    logic upd_event;
    logic upd_request;
    logic run_start;

    // Freeze holds both counters while debug halts the core
    assign frozen = halt_s2_q && freeze_q; // [RULE19]
    assign counting = ctrl_q.run && !frozen; // [RULE21] [RULE13]
    // Divider end of period: one tick every div_act_q+1 clocks
    assign tick = counting && (div_cnt_q == div_act_q); // [RULE3] [RULE4]
    // Overflow at or above reload, so a lowered reload still wraps
    assign overflow = tick && (count_q >= reload_act_q); // [RULE7]

    // Events blocked while inhibited
    assign upd_event = !ctrl_q.inhibit && (overflow || wr_force); // [RULE15]
    // Forced events request only when source select is 0
    assign upd_request = !ctrl_q.inhibit
        && (overflow || (wr_force && !ctrl_q.source)); // [RULE14]

    // Start: run bit written from 0 to 1
    assign run_start = wr_ctrl && pwdata[basic_timer_pkg::run_pos] && !ctrl_q.run;

    // Divider counter
    // Counts 0 to the active divider value, then wraps
    // Forced updates restart it even while inhibited,
    // so the next tick is one full divided period away
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_cnt_q <= '0;
        end else if (wr_force) begin
            div_cnt_q <= '0; // [RULE16] [RULE26]
        end else if (tick) begin
            div_cnt_q <= '0;
        end else if (counting) begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // Main counter
    // Priority: forced update, overflow, tick, then a
    // software write; a write that meets a tick is lost
    // Reload 0 overflows on every tick
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_q <= basic_timer_pkg::count_rst;
        end else if (wr_force) begin
            count_q <= '0; // [RULE8] [RULE16]
        end else if (overflow) begin
            count_q <= '0; // [RULE6] [RULE11]
        end else if (tick) begin
            count_q <= count_q + 1'b1; // [RULE1] [RULE2]
        end else if (wr_count) begin
            count_q <= pwdata[count_width-1:0];
        end
    end

    // Divider buffer and active value
    // A write landing on an update edge is taken at once
    // rather than waiting a whole further period
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_buf_q <= '0;
            div_act_q <= '0;
        end else begin
            if (wr_div) begin
                div_buf_q <= pwdata[divider_width-1:0]; // [RULE5]
            end
            if (upd_event) begin
                div_act_q <= wr_div ? pwdata[divider_width-1:0] : div_buf_q; // [RULE9]
            end
        end
    end

    // Reload buffer and active value
    // Buffer disabled: a write becomes the compare value
    // at once, so a value below the count wraps at the next tick
    // Inhibited updates leave the active value alone
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reload_buf_q <= '0;
            reload_act_q <= '0;
        end else begin
            if (wr_reload) begin
                reload_buf_q <= pwdata[count_width-1:0];
            end
            if (wr_reload && !ctrl_q.reload_buf) begin
                reload_act_q <= pwdata[count_width-1:0]; // [RULE10] [RULE25]
            end else if (upd_event) begin
                reload_act_q <= reload_buf_q; // [RULE9] [RULE15]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    // One-shot ends the run on any update, forced ones too;
    // a software write in the same cycle takes precedence
    // Reserved bits are dropped on write and read zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            ctrl_q.run <= pwdata[basic_timer_pkg::run_pos];
            ctrl_q.inhibit <= pwdata[basic_timer_pkg::inhibit_pos];
            ctrl_q.source <= pwdata[basic_timer_pkg::source_pos];
            ctrl_q.one_shot <= pwdata[basic_timer_pkg::one_shot_pos];
            ctrl_q.reload_buf <= pwdata[basic_timer_pkg::reload_buf_pos];
        end else if (ctrl_q.one_shot && upd_event) begin
            ctrl_q.run <= 1'b0; // [RULE11] [RULE12]
        end
    end

    // Other configuration registers
    // Only the fields named here are stored; the rest
    // of each word reads back as zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trig_sel_q <= '0;
            irq_en_q <= 1'b0;
            dma_en_q <= 1'b0;
            freeze_q <= 1'b0;
        end else begin
            if (wr_trig) begin
                trig_sel_q <= pwdata[basic_timer_pkg::trig_sel_lsb +: 3];
            end
            if (wr_enable) begin
                irq_en_q <= pwdata[basic_timer_pkg::irq_en_pos];
                dma_en_q <= pwdata[basic_timer_pkg::dma_en_pos];
            end
            if (wr_freeze) begin
                freeze_q <= pwdata[basic_timer_pkg::freeze_pos];
            end
        end
    end

    // Update flag: set wins over a software clear
    // Writing one leaves the flag as it is
    // Source select 1 keeps forced updates from setting it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            update_flag_q <= 1'b0;
        end else if (upd_request) begin
            update_flag_q <= 1'b1; // [RULE22]
        end else if (wr_status && !pwdata[basic_timer_pkg::flag_pos]) begin
            update_flag_q <= 1'b0; // [RULE22]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event outputs, one-cycle pulses
    // Registered so each output leaves a flip-flop;
    // pulses follow their cause by one clock
    // Reset trigger still fires on an inhibited force,
    // the update trigger stays quiet while inhibited
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            events <= '0;
        end else begin
            events.irq <= upd_request && irq_en_q; // [RULE17] [RULE23]
            events.dma <= upd_request && dma_en_q; // [RULE17] [RULE23] [RULE18]
            // Select codes other than the three stay silent
            unique case (trig_sel_q)
                basic_timer_pkg::trig_on_reset: events.trig <= wr_force; // [RULE24]
                basic_timer_pkg::trig_on_start: events.trig <= run_start; // [RULE24]
                basic_timer_pkg::trig_on_update: events.trig <= upd_event; // [RULE24] [RULE18]
                default: events.trig <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: zero wait states, registered read data
    // Read data is captured in the setup cycle and stands
    // only in the access cycle; it reads zero otherwise

    // Read multiplexer
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = '0;
        unique case (paddr)
            basic_timer_pkg::counter_control_off: begin
                rdata_d[basic_timer_pkg::run_pos] = ctrl_q.run;
                rdata_d[basic_timer_pkg::inhibit_pos] = ctrl_q.inhibit;
                rdata_d[basic_timer_pkg::source_pos] = ctrl_q.source;
                rdata_d[basic_timer_pkg::one_shot_pos] = ctrl_q.one_shot;
                rdata_d[basic_timer_pkg::reload_buf_pos] = ctrl_q.reload_buf;
            end
            basic_timer_pkg::trigger_control_off: rdata_d[basic_timer_pkg::trig_sel_lsb +: 3] = trig_sel_q;
            basic_timer_pkg::irq_dma_enable_off: begin
                rdata_d[basic_timer_pkg::irq_en_pos] = irq_en_q;
                rdata_d[basic_timer_pkg::dma_en_pos] = dma_en_q;
            end
            basic_timer_pkg::update_status_off: rdata_d[basic_timer_pkg::flag_pos] = update_flag_q;
            basic_timer_pkg::counter_value_off: rdata_d[count_width-1:0] = count_q;
            basic_timer_pkg::clock_divider_register_off: rdata_d[divider_width-1:0] = div_buf_q;
            basic_timer_pkg::reload_value_register_off: rdata_d[count_width-1:0] = reload_buf_q;
            basic_timer_pkg::debug_control_register_off: rdata_d[basic_timer_pkg::freeze_pos] = freeze_q;
            default: rdata_d = '0;
        endcase
    end

    // Setup cycle prepares answer; access cycle completes
    // An unmapped address is answered with pslverr, and
    // its write is dropped because no strobe decodes it
    // pready stands for exactly one cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
            pslverr <= psel && !penable && !mapped;
        end
    end

endmodule : basic_timer

`default_nettype wire

// ==== basic_timer_sva.sv ====
// Checker: APB timing and update event gating of the basic timer
`timescale 1ns/1ps
`default_nettype none

module basic_timer_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Debug and events
    input wire logic debug_halt,
    input wire basic_timer_pkg::events_t events
);
    logic wr_done;
    logic mapped;
    logic inhib_q, src_q, irq_en_q, dma_en_q;

    assign wr_done = psel && penable && pready && pwrite;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h28, 8'h2c, 8'h30};

    // Shadow of control and enable bits as software wrote them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            inhib_q <= 1'b0;
            src_q <= 1'b0;
            irq_en_q <= 1'b0;
            dma_en_q <= 1'b0;
        end else if (wr_done && paddr == 8'h00) begin
            inhib_q <= pwdata[1];
            src_q <= pwdata[2];
        end else if (wr_done && paddr == 8'h0c) begin
            irq_en_q <= pwdata[0];
            dma_en_q <= pwdata[8];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////////
    pready_timing_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    pready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_unmapped_a: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("no error on unmapped access");
    err_mapped_a: assert property (pslverr |-> pready && !mapped)
        else $error("error on mapped access");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    irq_gate_a: assert property (events.irq |-> $past(irq_en_q))
        else $error("interrupt while disabled");
    dma_gate_a: assert property (events.dma |-> $past(dma_en_q))
        else $error("dma request while disabled");
    inhibit_quiet_a: assert property (inhib_q && $past(inhib_q) |-> !events.irq && !events.dma)
        else $error("request while updates inhibited");
    force_event_a: assert property (wr_done && paddr == 8'h14 && pwdata[0] && !inhib_q && !src_q && irq_en_q
        |=> events.irq)
        else $error("forced update raised no interrupt");

    // Main scenarios reached
    cover property (events.irq);
    cover property (events.dma);
    cover property (events.trig);
    cover property (pslverr);
endmodule : basic_timer_sva

bind basic_timer basic_timer_sva i_basic_timer_sva (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_halt(debug_halt), .events(events));
`default_nettype wire

// ==== basic_timer_tb_top.sv ====
// Testbench: register level scenarios for the basic timer
`timescale 1ns/1ps
`default_nettype none

module basic_timer_tb_top;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic debug_halt = 1'b0;
    basic_timer_pkg::events_t events;
    int fails = 0;
    int n_compared = 0;
    int trig_seen = 0;
    int dma_seen = 0;
    int t0;
    int n;
    logic [31:0] rd;
    logic [31:0] v;
    logic err;

    // Clock, trigger and DMA pulse tally
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (events.trig === 1'b1) trig_seen <= trig_seen + 1;
    always @(posedge sys_clk) if (events.dma === 1'b1) dma_seen <= dma_seen + 1;

    basic_timer i_basic_timer (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_halt(debug_halt), .events(events));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            check(32'h0, 32'h1, "pready timeout");
            wrap_up();
        end
    endtask : apb

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0);
        check(rd, exp, what);
    endtask : rd_chk

    // Cycles until the next interrupt pulse
    task automatic wait_irq(output int cyc);
        for (cyc = 1; cyc < 2000; cyc++) begin
            @(posedge sys_clk);
            if (events.irq === 1'b1) break;
        end
        if (cyc == 2000) begin
            check(32'h0, 32'h1, "interrupt timeout");
            wrap_up();
        end
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        rd_chk(8'h00, 32'h0, "control reset");
        rd_chk(8'h2c, 32'h0, "reload reset");
        apb(1'b0, 8'h08, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        // Divider 0, unbuffered reload 2: update every 3 cycles
        apb(1'b1, 8'h0c, 32'h101);
        apb(1'b1, 8'h04, 32'h20);
        apb(1'b1, 8'h2c, 32'h2);
        apb(1'b1, 8'h00, 32'h1);
        wait_irq(n);
        wait_irq(n);
        check(32'(n), 32'h3, "period reload 2");
        check({31'h0, trig_seen > 0}, 32'h1, "trigger on update");
        check({31'h0, dma_seen > 0}, 32'h1, "dma on update");
        // Divider 1 waits for the next update
        apb(1'b1, 8'h28, 32'h1);
        wait_irq(n);
        check({31'h0, n <= 4}, 32'h1, "divider buffered");
        wait_irq(n);
        check(32'(n), 32'h6, "period divider 1");
        // Buffered reload 5
        apb(1'b1, 8'h00, 32'h81);
        apb(1'b1, 8'h2c, 32'h5);
        wait_irq(n);
        check({31'h0, n <= 7}, 32'h1, "reload buffered");
        wait_irq(n);
        check(32'(n), 32'hc, "period reload 5");
        // Stop holds the count, forced update clears it
        apb(1'b1, 8'h00, 32'h80);
        apb(1'b0, 8'h24, 32'h0);
        v = rd;
        rd_chk(8'h24, v, "held count");
        apb(1'b1, 8'h10, 32'h0);
        rd_chk(8'h10, 32'h0, "flag cleared");
        apb(1'b1, 8'h24, 32'h4);
        apb(1'b1, 8'h14, 32'h1);
        rd_chk(8'h24, 32'h0, "count after force");
        rd_chk(8'h14, 32'h0, "force bit clear");
        rd_chk(8'h10, 32'h1, "flag set");
        apb(1'b1, 8'h10, 32'h0);
        // Inhibited force: count cleared, no flag, reset trigger
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h24, 32'h9);
        t0 = trig_seen;
        apb(1'b1, 8'h14, 32'h1);
        rd_chk(8'h24, 32'h0, "inhibited force count");
        rd_chk(8'h10, 32'h0, "inhibited flag");
        check({31'h0, trig_seen > t0}, 32'h1, "trigger on reset");
        // Overflow-only source ignores forced update
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b1, 8'h14, 32'h1);
        rd_chk(8'h10, 32'h0, "source select flag");
        // One-shot run, start trigger
        apb(1'b1, 8'h04, 32'h10);
        t0 = trig_seen;
        apb(1'b1, 8'h00, 32'h9);
        wait_irq(n);
        check({31'h0, trig_seen > t0}, 32'h1, "trigger on start");
        rd_chk(8'h00, 32'h8, "one-shot run cleared");
        rd_chk(8'h24, 32'h0, "one-shot count");
        // Debug freeze
        apb(1'b1, 8'h30, 32'h1);
        debug_halt <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge sys_clk);
        rd_chk(8'h24, 32'h0, "frozen count");
        wrap_up();
    end
endmodule : basic_timer_tb_top
`default_nettype wire
